// ===== src/vector_place_pkg.sv
// Constants and carrier types for reset and interrupt vector placement.
// Assumes a single synchronous clock domain shared with the core fetch logic.
package vector_place_pkg;
	// ----------------------------------------------------------------
	// Table geometry
	// ----------------------------------------------------------------
	localparam int          NUM_VECTORS     = 21;
	localparam int          NUM_IRQ         = 20;
	localparam int          ADDR_W          = 16;
	localparam logic [15:0] RESET_VEC_ADDR  = 16'h0000;
	localparam logic [15:0] IRQ_TABLE_START = 16'h0002;
	localparam logic [15:0] IRQ_TABLE_LAST  = 16'h0028;
	localparam logic [15:0] VECTOR_STRIDE   = 16'h0002;
	localparam logic [15:0] BOOT_BASE_DEF   = 16'h1C00;
	// ----------------------------------------------------------------
	// Fuse and control encodings
	// ----------------------------------------------------------------
	localparam logic        FUSE_PROGRAMMED = 1'b0;
	localparam logic        SELECT_RESET    = 1'b0;
	localparam int          CHANGE_WINDOW   = 4;
	localparam logic [2:0]  WINDOW_RESET    = 3'h0;

	typedef struct packed {
		logic        valid;
		logic [4:0]  number;
		logic [15:0] addr;
	} vector_req_t;

	typedef enum logic [1:0] {
		ST_LOCKED = 2'b01,
		ST_OPEN   = 2'b10
	} change_state_t;
endpackage

// ===== src/vector_place.sv
// Reset and interrupt vector address generator for the core fetch unit.
// Assumes fuse and boot base are stable, control writes come from the core.
`timescale 1ns/1ns
module vector_place #(
	parameter logic [15:0] BOOT_BASE = vector_place_pkg::BOOT_BASE_DEF
) (
	input  wire logic                          REF_CLK,
	input  wire logic                          NRST,
	input  wire logic                          BOOT_RESET_FUSE,
	input  wire logic [vector_place_pkg::NUM_IRQ-1:0] IRQ_PENDING,
	input  wire logic                          IRQ_GLOBAL_EN,
	input  wire logic                          IRQ_ACK,
	input  wire logic                          CTRL_WRITE,
	input  wire logic                          VECTOR_SELECT_IN,
	input  wire logic                          VECTOR_CHANGE_ENABLE_IN,
	output logic [15:0]                        RESET_ADDR,
	output logic                               VECTOR_SELECT,
	output logic                               VECTOR_CHANGE_ENABLE,
	output logic                               IRQ_BLOCKED,
	output logic                               IRQ_REQ,
	output logic [4:0]                         IRQ_NUMBER,
	output logic [15:0]                        IRQ_ADDR
);
	// Odd or too high a base would split a vector pair or wrap the table
	if (BOOT_BASE[0] != 1'b0 || BOOT_BASE > 16'hFFD6) begin : g_bad_base
		$error("BOOT_BASE must be even and leave room for the table");
	end

	// ----------------------------------------------------------------
	// Vector select change window
	// ----------------------------------------------------------------
	vector_place_pkg::change_state_t state;
	logic [2:0]                      window;
	logic                            sel;
	logic                            open_req;
	logic                            sel_write;

	assign open_req  = CTRL_WRITE && VECTOR_CHANGE_ENABLE_IN;
	assign sel_write = CTRL_WRITE && !VECTOR_CHANGE_ENABLE_IN && state == vector_place_pkg::ST_OPEN;

	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			state  <= vector_place_pkg::ST_LOCKED;
			window <= vector_place_pkg::WINDOW_RESET;
		end else begin
			unique case (state)
				vector_place_pkg::ST_LOCKED: begin
					if (open_req) begin
						state  <= vector_place_pkg::ST_OPEN;
						window <= 3'(vector_place_pkg::CHANGE_WINDOW - 1);
					end
				end
				vector_place_pkg::ST_OPEN: begin
					if (open_req)
						window <= 3'(vector_place_pkg::CHANGE_WINDOW - 1);
					else if (sel_write || window == 3'h0)
						state <= vector_place_pkg::ST_LOCKED;
					else
						window <= window - 3'h1;
				end
				default: state <= vector_place_pkg::ST_LOCKED;
			endcase
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!NRST)
			sel <= vector_place_pkg::SELECT_RESET;
		else if (sel_write)
			sel <= VECTOR_SELECT_IN;
	end

	assign VECTOR_SELECT        = sel;
	assign VECTOR_CHANGE_ENABLE = (state == vector_place_pkg::ST_OPEN);
	// Interrupts held off while the table may be moving
	assign IRQ_BLOCKED          = (state == vector_place_pkg::ST_OPEN);

	// ----------------------------------------------------------------
	// Reset target
	// ----------------------------------------------------------------
	// fuse decode
	always_ff @(posedge REF_CLK) begin
		if (!NRST)
			RESET_ADDR <= (BOOT_RESET_FUSE == vector_place_pkg::FUSE_PROGRAMMED)
				? BOOT_BASE : vector_place_pkg::RESET_VEC_ADDR;
	end

	// ----------------------------------------------------------------
	// Interrupt selection
	// ----------------------------------------------------------------
	logic        any_pend;
	logic [4:0]  win_idx;
	logic [15:0] table_addr;
	logic [15:0] next_addr;

	always_comb begin
		any_pend = 1'b0;
		win_idx  = 5'h00;
		for (int i = vector_place_pkg::NUM_IRQ - 1; i >= 0; i--) begin
			if (IRQ_PENDING[i]) begin
				any_pend = 1'b1;
				win_idx  = 5'(i);
			end
		end
	end

	always_comb begin
		table_addr = vector_place_pkg::IRQ_TABLE_START
			+ 16'(win_idx) * vector_place_pkg::VECTOR_STRIDE;
		next_addr  = sel ? 16'(BOOT_BASE + table_addr) : table_addr;
	end

	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			IRQ_REQ    <= 1'b0;
			IRQ_NUMBER <= 5'h00;
			IRQ_ADDR   <= 16'h0000;
		end else if (!IRQ_REQ || IRQ_ACK) begin
			IRQ_REQ    <= any_pend && IRQ_GLOBAL_EN && !IRQ_BLOCKED && !IRQ_ACK;
			IRQ_NUMBER <= 5'(win_idx + 5'h02);
			IRQ_ADDR   <= next_addr;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_window_opened;
		$rose(VECTOR_CHANGE_ENABLE) && !open_req;
	endsequence

	sequence s_no_reopen;
		!open_req [*3];
	endsequence

	sequence s_no_write;
		!CTRL_WRITE [*3];
	endsequence

	property p_window_closes;
		@(posedge REF_CLK) disable iff (!NRST)
		s_window_opened ##1 s_no_reopen |=> !VECTOR_CHANGE_ENABLE;
	endproperty
	a_window_closes: assert property (p_window_closes) else $error("change window too long");

	property p_window_holds;
		@(posedge REF_CLK) disable iff (!NRST)
		s_window_opened ##0 !CTRL_WRITE ##1 s_no_write |-> VECTOR_CHANGE_ENABLE;
	endproperty
	a_window_holds: assert property (p_window_holds) else $error("change window too short");

	property p_sel_locked;
		@(posedge REF_CLK) disable iff (!NRST)
		state == vector_place_pkg::ST_LOCKED |=> $stable(sel);
	endproperty
	a_sel_locked: assert property (p_sel_locked) else $error("select changed while locked");

	property p_reset_addr;
		@(posedge REF_CLK) disable iff (!NRST)
		RESET_ADDR == vector_place_pkg::RESET_VEC_ADDR || RESET_ADDR == BOOT_BASE;
	endproperty
	a_reset_addr: assert property (p_reset_addr) else $error("bad reset address");

	property p_addr_range;
		@(posedge REF_CLK) disable iff (!NRST)
		IRQ_REQ && !sel |-> IRQ_ADDR >= vector_place_pkg::IRQ_TABLE_START
			&& IRQ_ADDR <= vector_place_pkg::IRQ_TABLE_LAST;
	endproperty
	a_addr_range: assert property (p_addr_range) else $error("vector outside table");

	property p_addr_number;
		@(posedge REF_CLK) disable iff (!NRST)
		IRQ_REQ |-> IRQ_ADDR == 16'((sel ? BOOT_BASE : 16'h0000) + 16'(IRQ_NUMBER - 5'h01) * 16'h0002);
	endproperty
	a_addr_number: assert property (p_addr_number) else $error("address mismatch");

	property p_no_req_blocked;
		@(posedge REF_CLK) disable iff (!NRST)
		$rose(IRQ_REQ) |-> $past(IRQ_GLOBAL_EN) && !$past(IRQ_BLOCKED) && $past(any_pend);
	endproperty
	a_no_req_blocked: assert property (p_no_req_blocked) else $error("request without cause");

	property p_lowest;
		@(posedge REF_CLK) disable iff (!NRST)
		any_pend |-> (IRQ_PENDING & ((20'h00001 << win_idx) - 20'h00001)) == 20'h00000;
	endproperty
	a_lowest: assert property (p_lowest) else $error("priority not lowest");

	property p_req_holds;
		@(posedge REF_CLK) disable iff (!NRST)
		IRQ_REQ && !IRQ_ACK |=> IRQ_REQ && $stable(IRQ_ADDR);
	endproperty
	a_req_holds: assert property (p_req_holds) else $error("request dropped");

	property p_select_lands;
		@(posedge REF_CLK) disable iff (!NRST)
		CTRL_WRITE && !VECTOR_CHANGE_ENABLE_IN && VECTOR_CHANGE_ENABLE
			|=> VECTOR_SELECT == $past(VECTOR_SELECT_IN) && !VECTOR_CHANGE_ENABLE;
	endproperty
	a_select_lands: assert property (p_select_lands) else $error("select write lost");

	property p_ack_drops;
		@(posedge REF_CLK) disable iff (!NRST)
		IRQ_REQ && IRQ_ACK |=> !IRQ_REQ;
	endproperty
	a_ack_drops: assert property (p_ack_drops) else $error("request kept after take");

	property p_num_range;
		@(posedge REF_CLK) disable iff (!NRST)
		IRQ_REQ |-> IRQ_NUMBER >= 5'h02
			&& IRQ_NUMBER <= 5'(vector_place_pkg::NUM_VECTORS);
	endproperty
	a_num_range: assert property (p_num_range) else $error("vector number out of range");
endmodule

// ===== bench/core_model.sv
// Core fetch stand-in that takes each presented vector after a set delay.
// Assumes one clock shared with the vector block and a delay held steady.
`timescale 1ns/1ns
module core_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       req,
	input  wire logic [1:0] delay,
	output logic            ack
);
	logic [1:0] cnt;

	always_ff @(posedge clk) begin
		if (!rst_n || ack) begin
			ack <= 1'b0;
			cnt <= 2'h0;
		end else if (req) begin
			if (cnt == delay)
				ack <= 1'b1;
			else
				cnt <= cnt + 2'h1;
		end
	end
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the vector placement block.
// Assumes the core model acks every request; expected vectors are queued.
`timescale 1ns/1ns
module testbench;
	localparam logic [15:0] BOOT = 16'h0C00;
	logic        clk, rst_n, fuse, gen, wr, sel_in, ce_in, sel_exp;
	logic        vsel, vce, blk, req, ack;
	logic [19:0] pend;
	logic [1:0]  dly;
	logic [15:0] raddr, iaddr;
	logic [4:0]  num;
	logic [20:0] exp_q[$];
	int          fail_count, checked;

	vector_place #(.BOOT_BASE(BOOT)) dut (.REF_CLK(clk), .NRST(rst_n),
		.BOOT_RESET_FUSE(fuse), .IRQ_PENDING(pend), .IRQ_GLOBAL_EN(gen), .IRQ_ACK(ack),
		.CTRL_WRITE(wr), .VECTOR_SELECT_IN(sel_in), .VECTOR_CHANGE_ENABLE_IN(ce_in),
		.RESET_ADDR(raddr), .VECTOR_SELECT(vsel), .VECTOR_CHANGE_ENABLE(vce),
		.IRQ_BLOCKED(blk), .IRQ_REQ(req), .IRQ_NUMBER(num), .IRQ_ADDR(iaddr));
	core_model core (.clk(clk), .rst_n(rst_n), .req(req), .delay(dly), .ack(ack));

	task automatic chk(logic [20:0] got, logic [20:0] want);
		checked++;
		if (got !== want) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask

	task automatic complete_run;
		// Notes never matched by a taken vector count as misses
		if (exp_q.size() != 0)
			fail_count++;
		if (fail_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic rst(logic f);
		@(posedge clk);
		rst_n <= 1'b0;
		fuse <= f;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		sel_exp = 1'b0;
		#1 chk(21'(raddr), f ? 21'h0 : 21'(BOOT));
	endtask

	task automatic ctrl(logic s, logic c);
		@(posedge clk);
		wr <= 1'b1;
		sel_in <= s;
		ce_in <= c;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	// Lowest pending bit wins, so only that one is noted
	task automatic serve(logic [19:0] m, logic b);
		int k, i;
		k = 0;
		i = 0;
		while (!m[i]) i++;
		exp_q.push_back({5'(i + 2), (sel_exp ? BOOT : 16'h0000) + 16'(2 * i + 2)});
		@(posedge clk);
		dly <= 2'($urandom);
		pend <= m;
		@(posedge clk);
		#1 chk(21'(req), 21'(!b));
		while (!(req && ack) && k < 40) begin
			@(posedge clk);
			gen <= 1'b1;
			#1 k++;
		end
		if (k == 40)
			fail_count++;
		@(posedge clk);
		pend <= 20'h0;
		@(posedge clk);
	endtask

	always @(posedge clk) begin
		if (req && ack)
			chk({num, iaddr}, exp_q.size() ? exp_q.pop_front() : 21'h1FFFFF);
	end

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial begin
		repeat (5000) @(posedge clk);
		fail_count++;
		complete_run;
	end

	initial begin
		{rst_n, wr, sel_in, ce_in, sel_exp, pend, dly} = '0;
		fuse = 1'b1;
		gen = 1'b1;
		fail_count = 0;
		checked = 0;
		void'($urandom(32'h46FE));
		rst(1'b1);
		for (int i = 0; i < 20; i++) serve(20'h1 << i, 1'b0);
		repeat (8) serve(20'($urandom) | 20'h80000, 1'b0);
		@(posedge clk);
		gen <= 1'b0;
		serve(20'h10, 1'b1);
		ctrl(1'b0, 1'b1);
		chk(21'(blk), 21'h1);
		chk(21'(vce), 21'h1);
		serve(20'h4, 1'b1);
		ctrl(1'b0, 1'b1);
		ctrl(1'b1, 1'b0);
		sel_exp = 1'b1;
		chk(21'(vsel), 21'h1);
		chk(21'(vce), 21'h0);
		repeat (6) serve(20'($urandom) | 20'h80000, 1'b0);
		ctrl(1'b0, 1'b0);
		chk(21'(vsel), 21'h1);
		serve(20'h80000, 1'b0);
		rst(1'b0);
		chk(21'(vsel), 21'h0);
		serve(20'h1, 1'b0);
		complete_run;
	end
endmodule
